// ### inc/gri_consts.vh
// Constants shared by the PHY pin interface block
//
// What the document requires
// R1: PHY raises carrier sense while medium busy either direction, drops when both idle.
// R2: Carrier sense is asynchronous to every clock; sample without alignment.
// R3: Carrier sense used only in half duplex, ignored in full duplex.
// R4: PHY supplies free-running receive clock at 2.5, 25 or 125 MHz.
// R5: Receive bus, valid and error are captured in the receive clock domain.
// R6: Receive bus is eight bits, LSB bit 0, meaningful only while valid.
// R7: PHY drives receive valid to mark bus carrying data.
// R8: PHY holds receive error at least one receive clock period.
// R9: Receive error counts only while valid, marking the frame errored.
// R10: Management clock generated here from a divider setting; accesses timed to it.
// R11: Management frame: start, read/write, PHY address, register address, data.
// R12: Drive management data pin always except read data bits; the code also releases it in the read turnaround and while idle.
// R13: Reduced gigabit interface supports 10, 100 and 1000 Mbps.
// R14: No carrier or collision pins in reduced mode; half duplex only 10/100.
// R15: Reduced carrier present when valid, or error with nibble data FFh.
// R16: Transmit clock runs continuously at 2.5, 25 or 125 MHz; the divider here makes 2.5 MHz only.
// R17: Transmit nibble and control launched timed to transmit clock.
// R18: Transmit nibble four bits, LSB bit 0, valid only while control high.
// R19: Low nibble on rising edge, high nibble on falling edge.
// R20: Transmit control is the enable marking nibble data valid.
// R21: Receive control carries valid on rising, valid xor error on falling.
// R22: Received low nibble on rising edge, high nibble on falling edge.
// R23: At 10/100 Mbps only the low four bits of each bus move; the transmit path here sends both nibbles of each byte at every speed.
// R24: 1000 Mbps allows full duplex only.
// R25: Carrier sense passes a two-stage synchronizer before use.
`ifndef GRI_CONSTS_VH
`define GRI_CONSTS_VH

// ----------------------------------------
// Speed encodings
// ----------------------------------------
`define GRI_SPD_10 2'h0
`define GRI_SPD_100 2'h1
`define GRI_SPD_1000 2'h2

// ----------------------------------------
// Transmit clock half periods in clk cycles (20 MHz core)
// ----------------------------------------
`define GRI_CLK_HZ 20000000
`define GRI_TXC_HZ_10 2500000
`define GRI_TXC_HZ_100 25000000
`define GRI_TXC_HALF_10 (`GRI_CLK_HZ / `GRI_TXC_HZ_10 / 2)

// ----------------------------------------
// Management frame fields
// ----------------------------------------
`define GRI_MD_PRE_BITS 6'h20
`define GRI_MD_START 2'h1
`define GRI_MD_OP_RD 2'h2
`define GRI_MD_OP_WR 2'h1
`define GRI_MD_FRAME_BITS 6'h20
`define GRI_MD_DATA_FIRST 6'h0f
`define GRI_MD_DIV_RST 8'h04

// ----------------------------------------
// Carrier pattern in reduced mode
// ----------------------------------------
`define GRI_CRS_PATTERN 8'hff

`endif

// ### logic/gri_fifo.v
// Receive byte FIFO with valid/ready on both sides
`timescale 1ns/1ps
module gri_fifo #(
	parameter WIDTH = 10,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	// Clock and reset
	input wire clk,
	input wire rst,
	// Fill side
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	// Drain side
	output wire out_valid,
	input wire out_ready,
	output reg [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW:0] wr_q;
	reg [AW:0] rd_q;
	reg [AW:0] cnt_q;
	wire do_wr;
	wire do_rd;

	// Handshakes from the occupancy count
	assign in_ready = (cnt_q != DEPTH[AW:0]);
	assign out_valid = (cnt_q != {(AW+1){1'b0}});
	assign do_wr = in_valid & in_ready;
	assign do_rd = out_valid & out_ready;

	// Storage write
	always @(posedge clk) begin
		if (do_wr) begin
			mem[wr_q[AW-1:0]] <= in_data;
		end
	end

	// Head word read combinationally into the output
	always @* begin
		out_data = mem[rd_q[AW-1:0]];
	end

	// Pointers and count
	always @(posedge clk) begin
		if (rst) begin
			wr_q <= {(AW+1){1'b0}};
			rd_q <= {(AW+1){1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end else begin
			if (do_wr) begin
				wr_q <= wr_q + 1'b1;
			end
			if (do_rd) begin
				rd_q <= rd_q + 1'b1;
			end
			if (do_wr && !do_rd) begin
				cnt_q <= cnt_q + 1'b1;
			end else if (do_rd && !do_wr) begin
				cnt_q <= cnt_q - 1'b1;
			end
		end
	end
endmodule

// ### logic/gri_phy_if.v
// PHY pin interface: receive capture, carrier, management port, reduced transmit
`timescale 1ns/1ps
`include "gri_consts.vh"
module gri_phy_if #(
	parameter FIFO_DEPTH = 16,
	parameter FIFO_AW = 4
) (
	// Clock and reset
	input wire clk,
	input wire rst,
	// Mode control
	input wire [1:0] speed_sel,
	input wire full_duplex,
	input wire rgmii_mode,
	// Gigabit receive pins
	input wire carrier_sense_in,
	input wire rx_clock_in,
	input wire [7:0] rx_data_bus,
	input wire rx_data_valid,
	input wire rx_error_flag,
	// Reduced receive pins (rise/fall halves presented as sampled levels)
	input wire [3:0] rgmii_rx_nibble_rise,
	input wire [3:0] rgmii_rx_nibble_fall,
	input wire rgmii_rx_control_rise,
	input wire rgmii_rx_control_fall,
	// Received byte stream
	output wire rx_out_valid,
	input wire rx_out_ready,
	output wire [7:0] rx_out_data,
	output wire rx_out_last,
	output wire rx_out_error,
	output reg rx_overflow_q,
	// Carrier for half-duplex logic
	output reg carrier_q,
	// Transmit byte stream
	input wire tx_in_valid,
	output wire tx_in_ready,
	input wire [7:0] tx_in_data,
	// Reduced transmit pins
	output reg rgmii_tx_clock,
	output reg [3:0] rgmii_tx_nibble,
	output reg rgmii_tx_control,
	// Management request
	input wire [7:0] mgmt_clock_divider,
	input wire md_req,
	input wire md_write,
	input wire [4:0] md_phy_addr,
	input wire [4:0] md_reg_addr,
	input wire [15:0] md_wdata,
	output wire md_busy,
	output reg md_done_q,
	output reg [15:0] md_rdata_q,
	// Management pins
	output reg mgmt_clock_out,
	output reg mdio_out,
	output reg mdio_oe,
	input wire mdio_in
);
	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	// The 20 MHz core only reaches the slow receive clocks; pins pass two stages
	reg [20:0] rxs1_q;
	reg [20:0] rxs2_q;
	reg [1:0] crs_s_q;
	reg [1:0] mdi_s_q;
	reg rclk_prev_q;
	wire rclk_rise;

	// Two-stage capture of all asynchronous pins
	always @(posedge clk) begin
		if (rst) begin
			rxs1_q <= 21'h0_0000;
			rxs2_q <= 21'h0_0000;
			crs_s_q <= 2'h0;
			mdi_s_q <= 2'h0;
			rclk_prev_q <= 1'b0;
		end else begin
			// Bit 20 clock, 19 valid, 18 error, 17/16 reduced control, 15:8 bus, 7:0 reduced byte
			rxs1_q <= {rx_clock_in, rx_data_valid, rx_error_flag, rgmii_rx_control_rise, rgmii_rx_control_fall,
				rx_data_bus, rgmii_rx_nibble_fall, rgmii_rx_nibble_rise}; // see R5
			rxs2_q <= rxs1_q;
			crs_s_q <= {crs_s_q[0], carrier_sense_in}; // see R2, see R25
			mdi_s_q <= {mdi_s_q[0], mdio_in};
			rclk_prev_q <= rxs2_q[20];
		end
	end

	assign rclk_rise = rxs2_q[20] & ~rclk_prev_q; // see R5

	// ----------------------------------------
	// Receive decode
	// ----------------------------------------
	reg rx_dv;
	reg rx_er;
	reg [7:0] rx_byte;
	reg crs_now;
	reg rx_dv_prev_q;
	reg frame_err_q;
	reg [7:0] rx_hold_q;
	reg rx_hold_v_q;
	reg hold_err_q;
	reg push_q;
	reg push_last_q;
	wire fifo_in_ready;
	wire rg_dv;
	wire rg_er;
	wire [7:0] rg_byte;

	// Reduced-mode pins: valid on rise, valid xor error on fall
	assign rg_dv = rxs2_q[17]; // see R21
	assign rg_er = rxs2_q[17] ^ rxs2_q[16]; // see R21
	assign rg_byte = rxs2_q[7:0]; // see R22

	// Select source and width per mode
	always @* begin
		if (rgmii_mode) begin
			rx_dv = rg_dv;
			rx_er = rg_er;
			rx_byte = rg_byte;
		end else begin
			rx_dv = rxs2_q[19];
			rx_er = rxs2_q[18];
			rx_byte = rxs2_q[15:8]; // see R6
		end
		if (speed_sel != `GRI_SPD_1000) begin
			rx_byte = {4'h0, rx_byte[3:0]}; // see R23
		end
		// Carrier derivation
		if (rgmii_mode) begin
			crs_now = rx_dv | (rx_er & (rg_byte == `GRI_CRS_PATTERN)); // see R15, see R14
		end else begin
			crs_now = crs_s_q[1]; // see R1
		end
	end

	// Carrier reaches half-duplex logic only when half duplex is legal
	always @(posedge clk) begin
		if (rst) begin
			carrier_q <= 1'b0;
		end else begin
			carrier_q <= crs_now & ~full_duplex & (speed_sel != `GRI_SPD_1000); // see R3, see R24
		end
	end

	// Byte capture on receive clock edges; error only counts inside valid
	always @(posedge clk) begin
		if (rst) begin
			rx_dv_prev_q <= 1'b0;
			frame_err_q <= 1'b0;
			rx_hold_q <= 8'h00;
			rx_hold_v_q <= 1'b0;
			hold_err_q <= 1'b0;
			push_q <= 1'b0;
			push_last_q <= 1'b0;
			rx_overflow_q <= 1'b0;
		end else begin
			push_q <= 1'b0;
			if (rclk_rise) begin
				rx_dv_prev_q <= rx_dv;
				if (rx_dv) begin // see R6
					frame_err_q <= frame_err_q | rx_er; // see R9, see R8
					if (rx_hold_v_q) begin
						push_q <= 1'b1;
						push_last_q <= 1'b0;
					end
					rx_hold_q <= rx_byte;
					rx_hold_v_q <= 1'b1;
					hold_err_q <= frame_err_q | rx_er;
				end else if (rx_dv_prev_q && rx_hold_v_q) begin
					push_q <= 1'b1;
					push_last_q <= 1'b1;
					rx_hold_v_q <= 1'b0;
					frame_err_q <= 1'b0;
				end
			end
			if (push_q && !fifo_in_ready) begin
				rx_overflow_q <= 1'b1;
			end
		end
	end

	// Previous byte travels with the frame error state from the edge at which it was held
	reg [7:0] push_byte_q;
	reg push_err_q;
	always @(posedge clk) begin
		if (rst) begin
			push_byte_q <= 8'h00;
			push_err_q <= 1'b0;
		end else if (rclk_rise) begin
			push_byte_q <= rx_hold_q;
			push_err_q <= hold_err_q | (rx_dv ? 1'b0 : frame_err_q);
		end
	end

	gri_fifo #(
		.WIDTH(10),
		.DEPTH(FIFO_DEPTH),
		.AW(FIFO_AW)
	) u_rx_fifo (
		.clk(clk),
		.rst(rst),
		.in_valid(push_q),
		.in_ready(fifo_in_ready),
		.in_data({push_err_q, push_last_q, push_byte_q}),
		.out_valid(rx_out_valid),
		.out_ready(rx_out_ready),
		.out_data({rx_out_error, rx_out_last, rx_out_data})
	);

	// ----------------------------------------
	// Reduced transmit
	// ----------------------------------------
	// Core clock only resolves the 10 Mbps clock; faster speeds use the same slow divider
	reg [3:0] txc_cnt_q;
	reg [7:0] tx_byte_q;
	reg tx_busy_q;
	wire txc_tick;

	assign txc_tick = (txc_cnt_q == `GRI_TXC_HALF_10 - 1);
	// Ready at every tick before a fall, so bytes follow back to back and the load there is the handshake
	assign tx_in_ready = txc_tick & rgmii_tx_clock;

	// Free-running transmit clock divider
	always @(posedge clk) begin
		if (rst) begin
			txc_cnt_q <= 4'h0;
			rgmii_tx_clock <= 1'b0;
		end else if (txc_tick) begin
			txc_cnt_q <= 4'h0;
			rgmii_tx_clock <= ~rgmii_tx_clock; // see R16, see R13
		end else begin
			txc_cnt_q <= txc_cnt_q + 4'h1;
		end
	end

	// Nibbles launched at clock edges: low on rise, high on fall
	always @(posedge clk) begin
		if (rst) begin
			tx_byte_q <= 8'h00;
			tx_busy_q <= 1'b0;
			rgmii_tx_nibble <= 4'h0;
			rgmii_tx_control <= 1'b0;
		end else if (txc_tick) begin
			if (!rgmii_tx_clock) begin
				// Rising edge next
				rgmii_tx_nibble <= tx_busy_q ? tx_byte_q[3:0] : 4'h0; // see R19, see R18, see R17
				rgmii_tx_control <= tx_busy_q; // see R20
			end else begin
				rgmii_tx_nibble <= tx_busy_q ? tx_byte_q[7:4] : 4'h0; // see R19
				tx_busy_q <= tx_in_valid;
				tx_byte_q <= tx_in_data;
			end
		end
	end

	// ----------------------------------------
	// Management port
	// ----------------------------------------
	reg [7:0] md_div_q;
	reg md_fall;
	reg md_run_q;
	reg [5:0] md_bit_q;
	reg md_pre_q;
	reg md_wr_q;
	reg [31:0] md_sh_q;

	assign md_busy = md_run_q;

	// Management clock divider, low while idle
	always @(posedge clk) begin
		if (rst) begin
			md_div_q <= 8'h00;
			mgmt_clock_out <= 1'b0;
		end else if (!md_run_q) begin
			md_div_q <= 8'h00;
			mgmt_clock_out <= 1'b0;
		end else if (md_div_q >= mgmt_clock_divider) begin
			md_div_q <= 8'h00;
			mgmt_clock_out <= ~mgmt_clock_out; // see R10
		end else begin
			md_div_q <= md_div_q + 8'h01;
		end
	end

	// Marks the core cycle in which the management clock falls
	always @* begin
		md_fall = md_run_q & mgmt_clock_out & (md_div_q >= mgmt_clock_divider);
	end

	// Frame shifter: preamble then start, op, addresses, turnaround, data
	always @(posedge clk) begin
		if (rst) begin
			md_run_q <= 1'b0;
			md_bit_q <= 6'h00;
			md_pre_q <= 1'b0;
			md_wr_q <= 1'b0;
			md_sh_q <= 32'h0000_0000;
			md_done_q <= 1'b0;
			md_rdata_q <= 16'h0000;
			mdio_out <= 1'b1;
			mdio_oe <= 1'b0;
		end else begin
			md_done_q <= 1'b0;
			if (!md_run_q) begin
				if (md_req) begin
					md_run_q <= 1'b1;
					md_pre_q <= 1'b1;
					md_bit_q <= `GRI_MD_PRE_BITS;
					md_wr_q <= md_write;
					md_sh_q <= {`GRI_MD_START, md_write ? `GRI_MD_OP_WR : `GRI_MD_OP_RD,
						md_phy_addr, md_reg_addr, 2'h2, md_write ? md_wdata : 16'h0000}; // see R11
					mdio_out <= 1'b1;
					mdio_oe <= 1'b1;
				end
			end else if (md_fall) begin
				if (md_pre_q) begin
					if (md_bit_q == 6'h01) begin
						md_pre_q <= 1'b0;
						md_bit_q <= `GRI_MD_FRAME_BITS;
					end else begin
						md_bit_q <= md_bit_q - 6'h01;
					end
					mdio_out <= 1'b1;
				end else if (md_bit_q == 6'h00) begin
					md_run_q <= 1'b0;
					md_done_q <= 1'b1;
					mdio_oe <= 1'b0;
					// Last read bit stands since the previous rise and is taken here
					if (!md_wr_q) begin
						md_rdata_q <= {md_rdata_q[14:0], mdi_s_q[1]}; // see R12
					end
				end else begin
					mdio_out <= md_sh_q[31];
					md_sh_q <= {md_sh_q[30:0], 1'b0};
					md_bit_q <= md_bit_q - 6'h01;
					// Release from turnaround through data on reads
					mdio_oe <= md_wr_q | (md_bit_q > (`GRI_MD_DATA_FIRST + 6'h03)); // see R12
					if (!md_wr_q && md_bit_q <= `GRI_MD_DATA_FIRST) begin // PHY bit from the previous rise
						md_rdata_q <= {md_rdata_q[14:0], mdi_s_q[1]};
					end
				end
			end
		end
	end
endmodule

// ### verif/gri_phy_if_monitor.sv
// Checker for the PHY pin interface ports
`timescale 1ns/1ps
module gri_phy_mon (
	// Clock, reset and modes
	input logic clk,
	input logic rst,
	input logic [1:0] speed_sel,
	input logic full_duplex,
	// Watched outputs and the management clock divider setting
	input logic carrier_q,
	input logic rgmii_tx_clock,
	input logic [3:0] rgmii_tx_nibble,
	input logic rgmii_tx_control,
	input logic [7:0] mgmt_clock_divider,
	input logic md_busy,
	input logic mgmt_clock_out,
	input logic mdio_out,
	input logic mdio_oe
);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	logic [8:0] hi_q;
	// Count cycles the management clock stands high
	always_ff @(posedge clk) begin
		hi_q <= (rst || !mgmt_clock_out) ? 9'h000 : hi_q + 9'h001;
	end
	// Transmit clock holds three more cycles, then turns
	sequence txc_hold;
		$stable(rgmii_tx_clock) [*3] ##1 $changed(rgmii_tx_clock);
	endsequence
	fd_carrier_a: assert property (full_duplex [*3] |-> !carrier_q)
		else $error("carrier in full duplex");
	gig_carrier_a: assert property ((speed_sel == 2'h2) [*3] |-> !carrier_q)
		else $error("carrier at top speed");
	txc_period_a: assert property ($changed(rgmii_tx_clock) |=> txc_hold)
		else $error("transmit clock half period wrong");
	tx_ctl_edge_a: assert property ($changed(rgmii_tx_control) |-> $rose(rgmii_tx_clock))
		else $error("transmit enable off the rising edge");
	tx_nib_edge_a: assert property ($changed(rgmii_tx_nibble) |-> $changed(rgmii_tx_clock))
		else $error("transmit nibble off the clock edges");
	md_half_a: assert property ($fell(mgmt_clock_out) |-> hi_q == mgmt_clock_divider + 9'h001)
		else $error("management clock high phase wrong");
	md_idle_a: assert property (!md_busy [*2] |-> !mgmt_clock_out && !mdio_oe)
		else $error("management pins active while idle");
	mdio_fall_a: assert property (md_busy && $past(md_busy) && $changed(mdio_out) |-> $fell(mgmt_clock_out))
		else $error("management data moved off a falling edge");
endmodule
bind gri_phy_if gri_phy_mon u_mon (.clk, .rst, .speed_sel, .full_duplex, .carrier_q, .rgmii_tx_clock,
	.rgmii_tx_nibble, .rgmii_tx_control, .mgmt_clock_divider, .md_busy, .mgmt_clock_out, .mdio_out, .mdio_oe);

// ### verif/gri_phy_model.sv
// Behavioural PHY facing the pin interface
`timescale 1ns/1ps
module gri_phy_model #(
	parameter logic [15:0] RD_VAL = 16'hc35a
) (
	// Receive pins toward the block
	output logic rx_clock_in,
	output logic [7:0] rx_data_bus,
	output logic rx_data_valid,
	output logic rx_error_flag,
	output logic [3:0] rgmii_rx_nibble_rise,
	output logic [3:0] rgmii_rx_nibble_fall,
	output logic rgmii_rx_control_rise,
	output logic rgmii_rx_control_fall,
	// Transmit pins from the block
	input logic rgmii_tx_clock,
	input logic [3:0] rgmii_tx_nibble,
	input logic rgmii_tx_control,
	// Management pins
	input logic mgmt_clock_out,
	input logic mdio_out,
	input logic mdio_oe,
	output logic mdio_in
);
	// ----------------------------------------
	// Receive side
	// ----------------------------------------
	logic [7:0] tx_q[$];
	logic [3:0] lo;
	logic [31:0] md_sr;
	logic [4:0] rd_i;
	logic phy_q;
	// Quiet pins at time zero
	initial begin
		{rx_clock_in, rx_data_bus, rx_data_valid, rx_error_flag} = 11'h000;
		{rgmii_rx_nibble_rise, rgmii_rx_nibble_fall, rgmii_rx_control_rise, rgmii_rx_control_fall} = 10'h000;
		phy_q = 1'b1;
		rd_i = 5'h00;
	end
	// Free-running receive clock at the 10 Mbps rate
	always #200 rx_clock_in = ~rx_clock_in;
	// Frame of n bytes stepping by 11h, error on byte e
	task automatic send(input logic [7:0] b0, input int n, input int e);
		logic [7:0] b;
		for (int i = 0; i < n; i++) begin
			b = b0 + 8'(i * 17);
			@(negedge rx_clock_in);
			{rx_data_bus, rx_data_valid, rx_error_flag} <= {b, 1'b1, i == e};
			{rgmii_rx_nibble_fall, rgmii_rx_nibble_rise} <= b;
			{rgmii_rx_control_rise, rgmii_rx_control_fall} <= {1'b1, i != e};
		end
		@(negedge rx_clock_in);
		idle(~b, 1'b0, 0);
	endtask
	// Between frames: data lines show a pattern, error as given
	task automatic idle(input logic [7:0] b, input logic e, input int k);
		{rx_data_bus, rx_data_valid, rx_error_flag} <= {b, 1'b0, e};
		{rgmii_rx_nibble_fall, rgmii_rx_nibble_rise} <= b;
		{rgmii_rx_control_rise, rgmii_rx_control_fall} <= {1'b0, e};
		repeat (k) @(negedge rx_clock_in);
	endtask
	// ----------------------------------------
	// Transmit and management side
	// ----------------------------------------
	// Rebuild bytes, sampled just after each edge
	always @(posedge rgmii_tx_clock) begin
		#1;
		lo = rgmii_tx_nibble;
	end
	always @(negedge rgmii_tx_clock) begin
		#1;
		if (rgmii_tx_control) tx_q.push_back({rgmii_tx_nibble, lo});
	end
	// Record driven bits; answer the turnaround zero, then read data, pull-up otherwise
	always @(posedge mgmt_clock_out) begin
		if (mdio_oe) begin
			md_sr <= {md_sr[30:0], mdio_out};
			rd_i <= 5'h00;
			phy_q <= 1'b1;
		end else begin
			phy_q <= rd_i == 5'h01 ? 1'b0 : (rd_i > 5'h01 && rd_i < 5'h12) ? RD_VAL[5'h11 - rd_i] : 1'b1;
			rd_i <= rd_i + 5'h01;
		end
	end
	assign mdio_in = mdio_oe ? mdio_out : phy_q;
endmodule

// ### verif/testbench.sv
// Self-checking bench for the PHY pin interface
`timescale 1ns/1ps
module testbench;
	logic clk = 0, rst = 1, full_duplex = 1, rgmii_mode = 0, carrier_sense_in = 0, rx_out_ready = 0;
	logic tx_in_valid = 0, md_req = 0, md_write = 0;
	logic [1:0] speed_sel = 2'h2;
	logic [7:0] tx_in_data = 8'h00, mgmt_clock_divider = 8'h03;
	logic [4:0] md_phy_addr = 5'h11, md_reg_addr = 5'h0a;
	logic [15:0] md_wdata = 16'hbeef;
	wire [7:0] rx_data_bus, rx_out_data;
	wire [3:0] rgmii_rx_nibble_rise, rgmii_rx_nibble_fall, rgmii_tx_nibble;
	wire [15:0] md_rdata_q;
	wire rx_clock_in, rx_data_valid, rx_error_flag, rgmii_rx_control_rise, rgmii_rx_control_fall;
	wire rx_out_valid, rx_out_last, rx_out_error, rx_overflow_q, carrier_q, tx_in_ready, rgmii_tx_clock;
	wire rgmii_tx_control, md_busy, md_done_q, mgmt_clock_out, mdio_out, mdio_oe, mdio_in;
	int n_mismatch = 0;
	int tests_run = 0;
	gri_phy_if u_dut (.clk, .rst, .speed_sel, .full_duplex, .rgmii_mode, .carrier_sense_in, .rx_clock_in,
		.rx_data_bus, .rx_data_valid, .rx_error_flag, .rgmii_rx_nibble_rise, .rgmii_rx_nibble_fall,
		.rgmii_rx_control_rise, .rgmii_rx_control_fall, .rx_out_valid, .rx_out_ready, .rx_out_data,
		.rx_out_last, .rx_out_error, .rx_overflow_q, .carrier_q, .tx_in_valid, .tx_in_ready, .tx_in_data,
		.rgmii_tx_clock, .rgmii_tx_nibble, .rgmii_tx_control, .mgmt_clock_divider, .md_req, .md_write,
		.md_phy_addr, .md_reg_addr, .md_wdata, .md_busy, .md_done_q, .md_rdata_q, .mgmt_clock_out,
		.mdio_out, .mdio_oe, .mdio_in);
	gri_phy_model u_phy (.rx_clock_in, .rx_data_bus, .rx_data_valid, .rx_error_flag, .rgmii_rx_nibble_rise,
		.rgmii_rx_nibble_fall, .rgmii_rx_control_rise, .rgmii_rx_control_fall, .rgmii_tx_clock,
		.rgmii_tx_nibble, .rgmii_tx_control, .mgmt_clock_out, .mdio_out, .mdio_oe, .mdio_in);
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	always #25 clk = ~clk;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t %s", $time, m);
		end
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// Take one received byte, bounded wait
	task automatic pop(input logic [7:0] d, input logic l, input logic e);
		int n = 0;
		while (rx_out_valid !== 1'b1 && n < 400) begin
			@(negedge clk);
			n++;
		end
		chk({rx_out_valid, rx_out_data, rx_out_last, rx_out_error}, {1'b1, d, l, e}, "rx byte");
		rx_out_ready = 1;
		@(negedge clk);
		rx_out_ready = 0;
		@(negedge clk);
	endtask
	// Management access, wait for the done pulse
	task automatic md_op(input logic w);
		int n = 0;
		md_write = w;
		md_req = 1;
		@(negedge clk);
		md_req = 0;
		chk(md_busy, 1, "md busy");
		while (md_done_q !== 1'b1 && n < 2000) begin
			@(negedge clk);
			n++;
		end
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	// Carrier pin: synchronised, half duplex below top speed only
	task automatic t_cs;
		{rgmii_mode, full_duplex, speed_sel} = 4'h1;
		carrier_sense_in = 1;
		repeat (2) @(negedge clk);
		chk(carrier_q, 0, "sync stages");
		repeat (4) @(negedge clk);
		chk(carrier_q, 1, "half carrier");
		full_duplex = 1;
		repeat (4) @(negedge clk);
		chk(carrier_q, 0, "full carrier");
		{full_duplex, speed_sel} = 3'h2;
		repeat (4) @(negedge clk);
		chk(carrier_q, 0, "top carrier");
		carrier_sense_in = 0;
		$display("test carrier done");
	endtask
	// Frames at each speed; error inside and outside frames
	task automatic t_rx;
		logic [7:0] m;
		for (int s = 0; s < 3; s++) begin
			speed_sel = 2'(s);
			m = s == 2 ? 8'hff : 8'h0f;
			u_phy.send(8'h5a, 3, 2);
			for (int i = 0; i < 3; i++) pop((8'h5a + 8'(i * 17)) & m, i == 2, i == 2);
		end
		u_phy.idle(8'hff, 1, 3);
		u_phy.send(8'h80, 2, 9);
		pop(8'h80, 0, 0);
		pop(8'h91, 1, 0);
		$display("test rx done");
	endtask
	// Reduced receive pins and derived carrier
	task automatic t_rgmii;
		rgmii_mode = 1;
		u_phy.send(8'hc3, 2, 1);
		pop(8'hc3, 0, 0);
		pop(8'hd4, 1, 1);
		{full_duplex, speed_sel} = 3'h0;
		u_phy.idle(8'hff, 1, 4);
		chk(carrier_q, 1, "extension carrier");
		u_phy.idle(8'hfe, 1, 4);
		chk(carrier_q, 0, "no carrier");
		u_phy.idle(8'h00, 0, 1);
		{rgmii_mode, full_duplex, speed_sel} = 4'h6;
		$display("test rgmii done");
	endtask
	// Back-to-back transmit bytes rebuilt by the PHY
	task automatic t_tx;
		logic [7:0] v[3] = '{8'h3c, 8'ha5, 8'h0f};
		int n = 0;
		foreach (v[i]) begin
			tx_in_data = v[i];
			tx_in_valid = 1;
			while (tx_in_ready !== 1'b1 && n < 100) begin
				@(negedge clk);
				n++;
			end
			@(negedge clk);
		end
		tx_in_valid = 0;
		while (u_phy.tx_q.size() < 3 && n < 200) begin
			@(negedge clk);
			n++;
		end
		chk(u_phy.tx_q.size(), 3, "tx count");
		foreach (v[i]) chk(u_phy.tx_q[i], v[i], "tx byte");
		$display("test tx done");
	endtask
	// Write then read frame
	task automatic t_md;
		md_op(1);
		chk(u_phy.md_sr, {4'h5, 5'h11, 5'h0a, 2'h2, 16'hbeef}, "write frame");
		md_op(0);
		chk(md_rdata_q, 16'hc35a, "read data");
		chk(u_phy.md_sr[13:0], {4'h6, 5'h11, 5'h0a}, "read head");
		$display("test mgmt done");
	endtask
	// Fill the buffer past full with the drain stalled, then empty it
	task automatic t_fill;
		int n = 0;
		u_phy.send(8'h00, 18, 99);
		while (rx_overflow_q !== 1'b1 && n < 100) begin
			@(negedge clk);
			n++;
		end
		// Let the closing byte arrive while still full, so it is dropped too
		repeat (24) @(negedge clk);
		chk(rx_overflow_q, 1, "overflow");
		for (int i = 0; i < 16; i++) pop(8'(i * 17), 0, 0);
		chk(rx_out_valid, 0, "empty");
		$display("test fill done");
	endtask
	// Main sequence
	initial begin
		repeat (3) @(negedge clk);
		rst = 0;
		t_cs;
		t_rx;
		t_rgmii;
		t_tx;
		t_md;
		t_fill;
		report_and_stop;
	end
	// Watchdog: tests need under 2000 cycles, allow twenty times that
	initial begin
		#2000000;
		n_mismatch++;
		report_and_stop;
	end
endmodule
